// ---- hw/lpc_regs.sv ----
/*
  Loopback and poll control command bits with AXI4-Lite register access.
  Assumes MAC-side signals and buffer-management events are synchronous to aclk; receive pins are not.
*/
`timescale 1ns/10ps
module lpc_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eeprom_load_start,
  input wire logic eeprom_load_error,
  input wire logic transmitter_on,
  input wire logic rx_first_desc_done,
  input wire logic rx_last_desc_done,
  input wire logic rx_activity_done,
  input wire logic chain_in_progress,
  input wire lpc_pkg::lpc_mii_t mac_tx,
  input wire logic mac_tx_clk,
  input wire lpc_pkg::lpc_mii_t pin_rx,
  input wire logic pin_rx_clk,
  input wire logic pin_col,
  input wire logic pin_crs,
  output lpc_pkg::lpc_mii_t mac_rx,
  output logic mac_rx_clk,
  output logic mac_col,
  output logic full_duplex_force,
  output logic loop_mode,
  output logic mii_internal_loop_select,
  output logic rx_interrupt_flag,
  output lpc_pkg::lpc_poll_t poll_req,
  output logic chain_poll_enable,
  output logic [31:0] command_reg_three_out
);

  // Stored control bits
  logic [6:0] command_reg_two_q;
  logic [31:0] command_reg_three_q;
  logic rx_interrupt_flag_q;
  lpc_pkg::lpc_poll_t poll_q;
  logic rx_dmd_q;
  logic tx_dmd_q;
  logic tx_auto_pend_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;
  lpc_pkg::lpc_mii_t mac_rx_q;
  logic mac_rx_clk_q, mac_col_q, fdx_q, loop_q, ilp_q;
  logic chpoll_en_q;

  // Named control bits
  wire internal_loopback_enable = command_reg_two_q[lpc_pkg::INTERNAL_LOOPBACK_ENABLE_POS];
  wire external_loopback_enable = command_reg_two_q[lpc_pkg::EXTERNAL_LOOPBACK_ENABLE_POS];
  wire lookahead_rx_interrupt_enable = command_reg_two_q[lpc_pkg::LOOKAHEAD_RX_INTERRUPT_ENABLE_POS];
  wire chpoll_dis = command_reg_two_q[lpc_pkg::CHPOLL_POS];
  wire txpoll_dis = command_reg_two_q[lpc_pkg::TXPOLL_POS];

  // Write channel capture and decode
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire aw_now = aw_have_q | aw_take;
  wire w_now = w_have_q | w_take;
  wire [7:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
  wire wr_go = aw_now & w_now & ~bvalid_q;
  wire wr_command_reg_two = wr_go & (wa == lpc_pkg::COMMAND_REG_TWO_ADDR) & ws[0];
  wire wr_command_reg_three = wr_go & (wa == lpc_pkg::COMMAND_REG_THREE_ADDR);
  wire wr_cs3 = wr_go & (wa == lpc_pkg::CS3_ADDR) & ws[0];
  wire wr_cs4 = wr_go & (wa == lpc_pkg::CS4_ADDR) & ws[1];
  wire wr_cs7 = wr_go & (wa == lpc_pkg::CS7_ADDR) & ws[1];
  wire wr_dmd = wr_go & (wa == lpc_pkg::DMD_ADDR) & ws[0];
  wire wr_hit = (wa == lpc_pkg::COMMAND_REG_TWO_ADDR) | (wa == lpc_pkg::COMMAND_REG_THREE_ADDR) | (wa == lpc_pkg::CS3_ADDR)
              | (wa == lpc_pkg::CS4_ADDR) | (wa == lpc_pkg::CS7_ADDR) | (wa == lpc_pkg::DMD_ADDR);

  // Value plus mask update of the second command register
  wire byte0_value_bit = wd[lpc_pkg::COMMAND_REG_TWO_VAL_POS];
  wire [6:0] command_reg_two_vm = (command_reg_two_q & ~wd[6:0]) | ({7{byte0_value_bit}} & wd[6:0]);
  logic [6:0] command_reg_two_d;
  always_comb begin
    command_reg_two_d = command_reg_two_q;
    if (wr_command_reg_two) begin
      command_reg_two_d = command_reg_two_vm;
    end
    if (wr_cs3) begin
      command_reg_two_d[lpc_pkg::LOOKAHEAD_RX_INTERRUPT_ENABLE_POS] = wd[lpc_pkg::CS3_LOOKAHEAD_RX_INTERRUPT_ENABLE_POS];
    end
    if (wr_cs4) begin
      command_reg_two_d[lpc_pkg::TXPOLL_POS] = wd[lpc_pkg::CS4_TXPOLL_POS];
    end
    if (wr_cs7) begin
      command_reg_two_d[lpc_pkg::CHPOLL_POS] = wd[lpc_pkg::CS7_CHPOLL_POS];
    end
  end

  // Value plus mask update of the third command register, per byte lane
  logic [31:0] command_reg_three_d;
  always_comb begin
    command_reg_three_d = command_reg_three_q;
    for (int b = 0; b < 4; b++) begin
      if (wr_command_reg_three && ws[b]) begin
        for (int i = 0; i < 7; i++) begin
          if (wd[b*8+i]) begin
            command_reg_three_d[b*8+i] = wd[b*8+7];
          end
        end
      end
    end
  end

  // Demand bits, one-shot
  wire rx_dmd_w = wr_dmd & wd[lpc_pkg::DMD_RX_POS];
  wire tx_dmd_w = wr_dmd & wd[lpc_pkg::DMD_TX_POS];

  // Poll decisions
  wire tx_auto = ~txpoll_dis & (tx_auto_pend_q | rx_activity_done);
  // Demand and automatic requests share one transmit poll pulse
  wire tx_poll_d = transmitter_on & (tx_dmd_q | tx_auto);
  wire rx_poll_d = rx_dmd_q & (~chpoll_dis | chain_in_progress);
  wire rx_interrupt_flag_set = rx_last_desc_done | (lookahead_rx_interrupt_enable & rx_first_desc_done);

  // Read decode
  logic [31:0] rd_w;
  always_comb begin
    rd_w = 32'h0000_0000;
    case (s_axi_araddr)
      lpc_pkg::COMMAND_REG_TWO_ADDR: rd_w[6:0] = command_reg_two_q;
      lpc_pkg::COMMAND_REG_THREE_ADDR: rd_w = command_reg_three_q;
      lpc_pkg::CS3_ADDR: rd_w[lpc_pkg::CS3_LOOKAHEAD_RX_INTERRUPT_ENABLE_POS] = lookahead_rx_interrupt_enable;
      lpc_pkg::CS4_ADDR: rd_w[lpc_pkg::CS4_TXPOLL_POS] = txpoll_dis;
      lpc_pkg::CS7_ADDR: rd_w[lpc_pkg::CS7_CHPOLL_POS] = chpoll_dis;
      lpc_pkg::DMD_ADDR: rd_w[1:0] = {tx_dmd_q, rx_dmd_q};
      lpc_pkg::STS_ADDR: rd_w[0] = rx_interrupt_flag_q;
      default: rd_w = 32'h0000_0000;
    endcase
  end
  // Unmapped read addresses return zero with an error response
  wire rd_hit = (s_axi_araddr == lpc_pkg::COMMAND_REG_TWO_ADDR) | (s_axi_araddr == lpc_pkg::COMMAND_REG_THREE_ADDR)
              | (s_axi_araddr == lpc_pkg::CS3_ADDR) | (s_axi_araddr == lpc_pkg::CS4_ADDR)
              | (s_axi_araddr == lpc_pkg::CS7_ADDR) | (s_axi_araddr == lpc_pkg::DMD_ADDR)
              | (s_axi_araddr == lpc_pkg::STS_ADDR);
  wire ar_take = s_axi_arvalid & arready_q;
  wire rd_sts = ar_take & (s_axi_araddr == lpc_pkg::STS_ADDR);

  // Receive pins pass two flip-flops before any logic reads them
  // Pins bear no relation to aclk, so only the second stage is read
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  lpc_pkg::lpc_mii_t pin_rx_s;
  wire pin_rx_clk_s = pin_s2_q[2];
  wire pin_col_s = pin_s2_q[1];
  wire pin_crs_s = pin_s2_q[0];
  assign pin_rx_s = pin_s2_q[7:3];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= {pin_rx, pin_rx_clk, pin_col, pin_crs};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Loopback mode decode
  // Both bits set: internal path wins, loop mode and select both high
  wire loop_d = internal_loopback_enable | external_loopback_enable;
  wire fdx_d = internal_loopback_enable | external_loopback_enable;

  // AXI write channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= lpc_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      // Address and data both held: commit write, raise response
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready_q <= 1'b0;
        wready_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? lpc_pkg::RESP_OKAY : lpc_pkg::RESP_SLVERR;
      end else begin
        // Hold whichever half arrives first
        if (aw_take) begin
          aw_have_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
          awready_q <= 1'b0;
        end
        if (w_take) begin
          w_have_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
          wready_q <= 1'b0;
        end
        // Response accepted: open both channels again
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
          awready_q <= 1'b1;
          wready_q <= 1'b1;
        end
      end
    end
  end

  // AXI read channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= lpc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      // Capture data; channel stays closed until the response is taken
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_w;
      rresp_q <= rd_hit ? lpc_pkg::RESP_OKAY : lpc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Command registers; EEPROM start and error clear the third one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_reg_two_q <= lpc_pkg::COMMAND_REG_TWO_RESET;
      command_reg_three_q <= lpc_pkg::COMMAND_REG_THREE_RESET;
      chpoll_en_q <= ~lpc_pkg::COMMAND_REG_TWO_RESET[lpc_pkg::CHPOLL_POS];
    end else begin
      command_reg_two_q <= command_reg_two_d;
      chpoll_en_q <= ~command_reg_two_d[lpc_pkg::CHPOLL_POS];
      command_reg_three_q <= (eeprom_load_start | eeprom_load_error) ? lpc_pkg::COMMAND_REG_THREE_RESET : command_reg_three_d;
    end
  end

  // Interrupt flag (set wins), demands and poll requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_interrupt_flag_q <= 1'b0;
      rx_dmd_q <= 1'b0;
      tx_dmd_q <= 1'b0;
      tx_auto_pend_q <= 1'b0;
      poll_q <= '0;
    end else begin
      // Status read clears the flag; a new event in that cycle wins
      rx_interrupt_flag_q <= rx_interrupt_flag_set | (rx_interrupt_flag_q & ~rd_sts);
      rx_dmd_q <= rx_dmd_w | (rx_dmd_q & ~rx_poll_d);
      tx_dmd_q <= tx_dmd_w | (tx_dmd_q & ~tx_poll_d);
      // Pending only while the transmitter is off, so one receive end gives one poll
      tx_auto_pend_q <= tx_auto & ~transmitter_on;
      poll_q.rx_desc <= rx_poll_d;
      poll_q.tx_desc <= tx_poll_d;
    end
  end

  // MII loopback multiplexers, updated every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_rx_q <= '0;
      mac_rx_clk_q <= 1'b0;
      mac_col_q <= 1'b0;
      fdx_q <= 1'b0;
      loop_q <= 1'b0;
      ilp_q <= 1'b0;
    end else begin
      mac_rx_q <= internal_loopback_enable ? mac_tx : pin_rx_s;
      mac_rx_clk_q <= internal_loopback_enable ? mac_tx_clk : pin_rx_clk_s;
      // Collision masked whenever full duplex is forced
      mac_col_q <= fdx_d ? 1'b0 : (pin_col_s & pin_crs_s);
      fdx_q <= fdx_d;
      loop_q <= loop_d;
      ilp_q <= internal_loopback_enable;
    end
  end

  // Output drive
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign mac_rx = mac_rx_q;
  assign mac_rx_clk = mac_rx_clk_q;
  assign mac_col = mac_col_q;
  assign full_duplex_force = fdx_q;
  assign loop_mode = loop_q;
  assign mii_internal_loop_select = ilp_q;
  assign rx_interrupt_flag = rx_interrupt_flag_q;
  assign poll_req = poll_q;
  assign chain_poll_enable = chpoll_en_q;
  assign command_reg_three_out = command_reg_three_q;
endmodule

// ---- hw/lpc_pkg.sv ----
/*
  Package for the loopback and poll control register block.
  Assumes a 32-bit AXI4-Lite slave port and a 25 MHz clock.
*/
package lpc_pkg;
  // Register byte addresses
  localparam logic [7:0] COMMAND_REG_TWO_ADDR = 8'h50;
  localparam logic [7:0] COMMAND_REG_THREE_ADDR = 8'h54;
  localparam logic [7:0] CS3_ADDR = 8'h58;
  localparam logic [7:0] CS4_ADDR = 8'h5C;
  localparam logic [7:0] CS7_ADDR = 8'h60;
  localparam logic [7:0] DMD_ADDR = 8'h64;
  localparam logic [7:0] STS_ADDR = 8'h68;
  // Second command register fields
  localparam int COMMAND_REG_TWO_VAL_POS = 7;
  localparam int INTERNAL_LOOPBACK_ENABLE_POS = 4;
  localparam int EXTERNAL_LOOPBACK_ENABLE_POS = 3;
  localparam int LOOKAHEAD_RX_INTERRUPT_ENABLE_POS = 2;
  localparam int CHPOLL_POS = 1;
  localparam int TXPOLL_POS = 0;
  // Alias positions in legacy registers
  localparam int CS3_LOOKAHEAD_RX_INTERRUPT_ENABLE_POS = 5;
  localparam int CS7_CHPOLL_POS = 12;
  localparam int CS4_TXPOLL_POS = 12;
  // Demand register fields
  localparam int DMD_RX_POS = 0;
  localparam int DMD_TX_POS = 1;
  // Third command register value bits
  localparam int COMMAND_REG_THREE_VAL3_POS = 31;
  localparam int COMMAND_REG_THREE_VAL2_POS = 23;
  localparam int COMMAND_REG_THREE_VAL1_POS = 15;
  localparam int COMMAND_REG_THREE_BYTE0_VALUE_BIT_POS = 7;
  // Reset values
  localparam logic [6:0] COMMAND_REG_TWO_RESET = 7'h00;
  localparam logic [31:0] COMMAND_REG_THREE_RESET = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // MII nibble group
  typedef struct packed {
    logic [3:0] data;
    logic en;
  } lpc_mii_t;

  // Poll requests to the buffer management unit
  typedef struct packed {
    logic rx_desc;
    logic tx_desc;
  } lpc_poll_t;
endpackage

// ---- tb/lpc_regs_props.sv ----
/*
  Concurrent checks on the lpc_regs ports.
  Assumes one aclk domain and sync active-low aresetn.
*/
`timescale 1ns/10ps
module lpc_regs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lpc_pkg::lpc_mii_t mac_tx,
  input wire lpc_pkg::lpc_mii_t mac_rx,
  input wire logic mac_col,
  input wire logic full_duplex_force,
  input wire logic loop_mode,
  input wire logic mii_internal_loop_select,
  input wire lpc_pkg::lpc_poll_t poll_req,
  input wire logic transmitter_on,
  input wire logic rx_last_desc_done,
  input wire logic rx_interrupt_flag,
  input wire logic eeprom_load_start,
  input wire logic eeprom_load_error,
  input wire logic [31:0] command_reg_three_out,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_awready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Loopback datapath and duplex
  AST_INTERNAL_LOOPBACK_ENABLE_DATA: assert property (
    mii_internal_loop_select && $past(mii_internal_loop_select) |-> mac_rx == $past(mac_tx))
    else $error("looped data differs from transmit");
  AST_INTERNAL_LOOPBACK_ENABLE_NOCOL: assert property (
    mii_internal_loop_select && $past(mii_internal_loop_select) |-> !mac_col)
    else $error("collision seen in internal loop");
  AST_LOOP_FDX: assert property (
    loop_mode |-> full_duplex_force)
    else $error("loop without forced full duplex");
  AST_SELECT_MODE: assert property (
    mii_internal_loop_select |-> loop_mode)
    else $error("internal select without loop mode");
  // Events and polls
  AST_TX_POLL_ON: assert property (
    poll_req.tx_desc |-> $past(transmitter_on))
    else $error("transmit poll while transmitter off");
  AST_RX_INT: assert property (
    rx_last_desc_done |=> rx_interrupt_flag)
    else $error("receive interrupt not raised");
  AST_COMMAND_REG_THREE_CLEAR: assert property (
    eeprom_load_start || eeprom_load_error |=> command_reg_three_out == 32'h0)
    else $error("third command register not cleared");
  AST_AW_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
endmodule
bind lpc_regs lpc_regs_props i_lpc_regs_props (.*);

// ---- tb/loopback_and_poll_control_test.sv ----
/*
  Self-checking bench for lpc_regs over AXI4-Lite.
  Assumes lpc_pkg and a 25 MHz aclk.
*/
`timescale 1ns/10ps
module loopback_and_poll_control_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, transmitter_on;
  logic chain_in_progress, mac_tx_clk, pin_rx_clk, pin_col, pin_crs, mac_rx_clk, mac_col;
  logic full_duplex_force, loop_mode, mii_internal_loop_select, rx_interrupt_flag, chain_poll_enable;
  wire eeprom_load_start, eeprom_load_error, rx_first_desc_done, rx_last_desc_done, rx_activity_done;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, command_reg_three_out;
  logic [4:0] ev_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  lpc_pkg::lpc_mii_t mac_tx, pin_rx, mac_rx;
  lpc_pkg::lpc_poll_t poll_req;
  int error_cnt = 0;
  int checks_done = 0;
  int txp = 0;
  int rxp = 0;

  lpc_regs i_lpc_regs (.*);
  // Event pulses from one vector
  assign {eeprom_load_start, eeprom_load_error, rx_first_desc_done, rx_last_desc_done, rx_activity_done} = ev_q;
  always #20 aclk = ~aclk;
  // Count poll pulses
  always @(posedge aclk) begin
    txp <= txp + poll_req.tx_desc;
    rxp <= rxp + poll_req.rx_desc;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n > 60) begin
      error_cnt++;
      stop_test;
    end
  endtask

  // Settle point between edges
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic ev(input int k);
    @(posedge aclk);
    ev_q <= 5'h10 >> k;
    @(posedge aclk);
    ev_q <= 5'h0;
    cyc(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int n;
    logic [2:0] t;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    t = 3'h0;
    for (n = 0; !t[0]; n++) begin
      @(negedge aclk);
      t = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      r = s_axi_bresp;
      @(posedge aclk);
      if (t[2]) s_axi_awvalid <= 1'h0;
      if (t[1]) s_axi_wvalid <= 1'h0;
      if (t[0]) s_axi_bready <= 1'h0;
      hang(n);
    end
    chk(r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic [1:0] t;
    logic [33:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    t = 2'h0;
    for (n = 0; !t[0]; n++) begin
      @(negedge aclk);
      t = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
      r = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (t[1]) s_axi_arvalid <= 1'h0;
      if (t[0]) s_axi_rready <= 1'h0;
      hang(n);
    end
    chk(r[33:32], e);
    chk(r[31:0], d);
  endtask

  initial begin
    aclk = 1'h0;
    ev_q = 5'h0;
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr,
     s_axi_arvalid, s_axi_rready, transmitter_on, chain_in_progress, mac_tx, mac_tx_clk, pin_rx, pin_rx_clk,
     pin_col, pin_crs} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h54, 32'h0, 2'h0);
    rd(8'h7C, 32'h0, 2'h2);
    cyc(0);
    chk(chain_poll_enable, 1'h1);
    $display("reset test done");
    // Value and mask writes, internal then external loop
    wr(8'h50, 32'h91, 4'h1, 2'h0);
    rd(8'h50, 32'h11, 2'h0);
    wr(8'h50, 32'h82, 4'h1, 2'h0);
    wr(8'h50, 32'h9F, 4'h2, 2'h0);
    rd(8'h50, 32'h13, 2'h0);
    rd(8'h60, 32'h1000, 2'h0);
    rd(8'h5C, 32'h1000, 2'h0);
    chk(chain_poll_enable, 1'h0);
    mac_tx <= 5'h15;
    mac_tx_clk <= 1'h1;
    pin_rx <= 5'h0A;
    pin_col <= 1'h1;
    pin_crs <= 1'h1;
    cyc(2);
    chk({loop_mode, mii_internal_loop_select, full_duplex_force}, 3'h7);
    chk(mac_rx, 5'h15);
    chk(mac_rx_clk, 1'h1);
    chk(mac_col, 1'h0);
    wr(8'h50, 32'h10, 4'h1, 2'h0);
    wr(8'h50, 32'h88, 4'h1, 2'h0);
    cyc(2);
    chk({loop_mode, mii_internal_loop_select, full_duplex_force}, 3'h5);
    chk(mac_rx, 5'h0A);
    wr(8'h50, 32'h08, 4'h1, 2'h0);
    cyc(2);
    chk({loop_mode, full_duplex_force, mac_col}, 3'h1);
    $display("loopback test done");
    // Look-ahead interrupt through the alias
    wr(8'h58, 32'h20, 4'h1, 2'h0);
    rd(8'h50, 32'h07, 2'h0);
    ev(2);
    chk(rx_interrupt_flag, 1'h1);
    rd(8'h68, 32'h1, 2'h0);
    wr(8'h50, 32'h04, 4'h1, 2'h0);
    rd(8'h58, 32'h0, 2'h0);
    ev(2);
    chk(rx_interrupt_flag, 1'h0);
    ev(3);
    chk(rx_interrupt_flag, 1'h1);
    rd(8'h68, 32'h1, 2'h0);
    $display("interrupt test done");
    // Manual and automatic polls
    wr(8'h64, 32'h2, 4'h1, 2'h0);
    cyc(4);
    chk(txp, 0);
    @(posedge aclk);
    transmitter_on <= 1'h1;
    cyc(3);
    chk(txp, 1);
    wr(8'h64, 32'h1, 4'h1, 2'h0);
    cyc(3);
    chk(rxp, 0);
    @(posedge aclk);
    chain_in_progress <= 1'h1;
    cyc(2);
    chk(rxp, 1);
    wr(8'h64, 32'h1, 4'h1, 2'h0);
    cyc(3);
    chk(rxp, 2);
    wr(8'h60, 32'h0, 4'h2, 2'h0);
    cyc(2);
    chk(chain_poll_enable, 1'h1);
    ev(4);
    cyc(2);
    chk(txp, 1);
    wr(8'h5C, 32'h0, 4'h2, 2'h0);
    rd(8'h50, 32'h0, 2'h0);
    ev(4);
    cyc(2);
    chk(txp, 2);
    $display("poll test done");
    // Third command register clearing
    for (int k = 0; k < 3; k++) begin
      wr(8'h54, 32'h83, 4'hF, 2'h0);
      cyc(1);
      chk(command_reg_three_out, 32'h3);
      if (k < 2) begin
        ev(k);
      end else begin
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        cyc(0);
      end
      chk(command_reg_three_out, 32'h0);
    end
    rd(8'h54, 32'h0, 2'h0);
    $display("clear test done");
    stop_test;
  end
endmodule
